// ---- design/sfm_pkg.sv ----
/*
 File: shared constants for the solenoid fault SPI link (device and host ends).
 Assumes: both ends import this package; the link interface does not.
*/
package sfm_pkg;
   // -----------------------------------------------------------
   // Frame layout
   // -----------------------------------------------------------
   localparam int SFM_CHANNELS = 5;  // Monitor channels
   localparam int SFM_FRAME_BITS = 8;  // Bits per frame, MSB first
   localparam int SFM_CNT_W = 4;  // Bit counter width
   localparam logic [SFM_CNT_W-1:0] SFM_LAST_BIT = 4'h7;  // Index of final bit
   localparam logic [SFM_CNT_W-1:0] SFM_CNT_ZERO = 4'h0;  // Counter reset value
   localparam logic [7:0] SFM_BYTE_ZERO = 8'h00;  // Byte reset value
   localparam logic [SFM_CHANNELS-1:0] SFM_FAULT_ZERO = 5'h00;  // Fault reset value
   // -----------------------------------------------------------
   // Host clock divider
   // -----------------------------------------------------------
   localparam int SFM_SCLK_HALF = 8;  // Host clk cycles per sclk half period
   localparam logic [7:0] SFM_DIV_ZERO = 8'h00;  // Divider reset value
   // Host states
   typedef enum logic [3:0] {
      SFM_H_IDLE = 4'h1,
      SFM_H_LOW = 4'h2,
      SFM_H_HIGH = 4'h4,
      SFM_H_DONE = 4'h8
   } sfm_hstate_e;
endpackage

// ---- design/sfm_link_if.sv ----
/*
 File: SPI link between host master and solenoid monitor device.
 Assumes: the bench resolves so from so_out/so_oe; cs_n has no pull-up, the host drives it high when idle.
*/
`timescale 1ns/10ps
interface sfm_link_if;
   logic sclk;  // Serial clock from host
   logic cs_n;  // Chip select, active low
   logic si;  // Host to device data
   logic so_out;  // Device data out
   logic so_oe;  // Device drives so while high
   logic so_in;  // Resolved so level seen by host
   // Device end
   modport device (input sclk, input cs_n, input si, output so_out, output so_oe);
   // Host end
   modport host (output sclk, output cs_n, output si, input so_in);
endinterface

// ---- design/sfm_fifo.sv ----
/*
 File: flip-flop FIFO with valid/ready on both sides.
 Assumes: single clock domain.
*/
`timescale 1ns/10ps
module sfm_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_ff [DEPTH];  // Storage
   logic [AW-1:0] wr_ff;  // Write index
   logic [AW-1:0] rd_ff;  // Read index
   logic [AW:0] cnt_ff;  // Fill level
   logic push;
   logic pop;
   assign in_ready = (cnt_ff != DEPTH[AW:0]);  // Honest full
   assign out_valid = (cnt_ff != '0);  // Honest empty
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem_ff[rd_ff];
   // Storage write
   always_ff @(posedge clk) begin
      if (push) begin
         mem_ff[wr_ff] <= in_data;
      end
   end
   // Pointers and level
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wr_ff <= '0;
         rd_ff <= '0;
         cnt_ff <= '0;
      end else begin
         if (push) begin
            wr_ff <= (wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1;
         end
         if (pop) begin
            rd_ff <= (rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1;
         end
         cnt_ff <= cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      end
   end
endmodule

// ---- design/sfm_device.sv ----
/*
 File: solenoid monitor device end of the SPI link.
 Assumes: sclk is the link clock (stands still outside frames); fault events and
 the reset pin arrive on the core clock; user reads received bytes via a FIFO.
*/
// Functional notes
// - Serial output tri-stated while deselected
// - Serial output changes on sclk falling edges
// - Host samples so on rising edges; the host takes synced so late in each high phase, as it drives sclk low
// - Serial input captured on sclk rising edges
// - Host changes si on falling edges
// - Host drives select low per transfer
// - Select weakly pulled toward inactive high; the link has no pull-up, the host drives cs_n high when idle
// - Sclk ignored while select high
// - Host sclk has 50% duty cycle
// - Reset pin clears stored fault bits
// - Reset pin tri-states serial output
// - One fault bit per monitor channel
`timescale 1ns/10ps
module sfm_device
   import sfm_pkg::*;
#(
   parameter int FIFO_DEPTH = 16
) (
   // Core clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Link
   sfm_link_if.device link,
   // Reset pin, active high
   input wire logic reset_pin,
   // Fault events, one-cycle pulses per channel
   input wire logic [SFM_CHANNELS-1:0] fault_event,
   // Stored faults
   output logic [SFM_CHANNELS-1:0] fault_flags,
   // Received configuration bytes
   output logic cfg_valid,
   input wire logic cfg_ready,
   output logic [SFM_FRAME_BITS-1:0] cfg_data,
   output logic cfg_overflow
);
   // -----------------------------------------------------------
   // Core side: faults and reset pin
   // -----------------------------------------------------------
   logic [SFM_CHANNELS-1:0] fault_ff;  // Sticky fault bits
   logic rst_s1_ff;  // Reset pin sync stage 1
   logic rst_s2_ff;  // Reset pin sync stage 2
   logic clr_tog_s1_ff;  // Frame-read toggle sync stage 1
   logic clr_tog_s2_ff;  // Frame-read toggle sync stage 2
   logic clr_tog_s3_ff;  // Previous synced toggle
   logic clr_req;  // Pulse: host read a snapshot
   logic [SFM_CHANNELS-1:0] snap_ff;  // Bits sent in last frame (link domain)
   logic [SFM_CHANNELS-1:0] snap_core_ff;  // Faults offered to the next frame
   logic [SFM_CHANNELS-1:0] tx_snap_ff;  // Faults loaded into this frame (link)
   logic rd_tog_ff;  // Toggles when a full frame was read (link)
   logic cs_s1_ff;  // Select sync stage 1
   logic cs_s2_ff;  // Select sync stage 2
   // Reset pin synchroniser
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_s1_ff <= 1'b0;
         rst_s2_ff <= 1'b0;
      end else begin
         rst_s1_ff <= reset_pin;
         rst_s2_ff <= rst_s1_ff;
      end
   end
   // Read-done toggle synchroniser
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         clr_tog_s1_ff <= 1'b0;
         clr_tog_s2_ff <= 1'b0;
         clr_tog_s3_ff <= 1'b0;
      end else begin
         clr_tog_s1_ff <= rd_tog_ff;
         clr_tog_s2_ff <= clr_tog_s1_ff;
         clr_tog_s3_ff <= clr_tog_s2_ff;
      end
   end
   assign clr_req = clr_tog_s2_ff ^ clr_tog_s3_ff;
   // Select synchroniser: tells the core when a frame is under way
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cs_s1_ff <= 1'b1;
         cs_s2_ff <= 1'b1;
      end else begin
         cs_s1_ff <= link.cs_n;
         cs_s2_ff <= cs_s1_ff;
      end
   end
   // Snapshot follows the faults while deselected and freezes in a frame.
   // The link clock stands still between frames, so it cannot sync the
   // faults itself; the first falling edge comes long after the freeze.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         snap_core_ff <= SFM_FAULT_ZERO;
      end else if (cs_s2_ff) begin
         snap_core_ff <= fault_ff;
      end
   end
   // per-channel sticky faults, generate per bit
   for (genvar i = 0; i < SFM_CHANNELS; i++) begin : g_fault
      always_ff @(posedge clk or negedge arst_n) begin
         if (!arst_n) begin
            fault_ff[i] <= 1'b0;
         end else if (rst_s2_ff) begin
            fault_ff[i] <= 1'b0;
         // Set wins over clear-on-read
         end else if (fault_event[i]) begin
            fault_ff[i] <= 1'b1;
         end else if (clr_req && snap_ff[i]) begin
            fault_ff[i] <= 1'b0;
         end
      end
   end
   assign fault_flags = fault_ff;
   // -----------------------------------------------------------
   // Link side: shifters on sclk
   // -----------------------------------------------------------
   logic [SFM_CNT_W-1:0] rx_cnt_ff;  // Rising-edge bit counter
   logic [SFM_FRAME_BITS-1:0] rx_sh_ff;  // Input shifter
   logic [SFM_FRAME_BITS-1:0] tx_sh_ff;  // Output shifter
   logic so_ff;  // Output bit
   logic wr_tog_ff;  // Toggles when a byte is received
   logic [SFM_FRAME_BITS-1:0] rx_hold_ff;  // Received byte held for crossing
   logic frame_rst_n;  // Frame ends on select high
   // select high ends frame and resets counters
   // no pull-up in the interface wire; the host drives cs_n high when idle
   // select high holds the shifters and counters in reset and gates the byte hold, so sclk is ignored
   assign frame_rst_n = arst_n && !link.cs_n;
   always_ff @(posedge link.sclk or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         rx_cnt_ff <= SFM_CNT_ZERO;
         rx_sh_ff <= SFM_BYTE_ZERO;
      end else begin
         rx_sh_ff <= {rx_sh_ff[SFM_FRAME_BITS-2:0], link.si};
         rx_cnt_ff <= (rx_cnt_ff == SFM_LAST_BIT) ? SFM_CNT_ZERO : rx_cnt_ff + 1'b1;
      end
   end
   // Full byte: hold it and toggle towards the core; not reset by select
   always_ff @(posedge link.sclk or negedge arst_n) begin
      if (!arst_n) begin
         rx_hold_ff <= SFM_BYTE_ZERO;
         wr_tog_ff <= 1'b0;
         rd_tog_ff <= 1'b0;
         snap_ff <= SFM_FAULT_ZERO;
      end else if (!link.cs_n && rx_cnt_ff == SFM_LAST_BIT) begin
         rx_hold_ff <= {rx_sh_ff[SFM_FRAME_BITS-2:0], link.si};
         wr_tog_ff <= ~wr_tog_ff;
         rd_tog_ff <= ~rd_tog_ff;
         snap_ff <= tx_snap_ff;
      end
   end
   // output shifter advances on falling edge
   logic tx_loaded_ff;  // First falling edge loads the snapshot
   always_ff @(negedge link.sclk or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         tx_sh_ff <= SFM_BYTE_ZERO;
         so_ff <= 1'b0;
         tx_loaded_ff <= 1'b0;
         tx_snap_ff <= SFM_FAULT_ZERO;
      end else if (!tx_loaded_ff) begin
         // Frame bit 6 launched (bit 7 is the reset zero): faults MSB first, then zero padding
         tx_loaded_ff <= 1'b1;
         tx_snap_ff <= snap_core_ff;
         tx_sh_ff <= {snap_core_ff[SFM_CHANNELS-2:0], {(SFM_FRAME_BITS-SFM_CHANNELS+1){1'b0}}};
         so_ff <= snap_core_ff[SFM_CHANNELS-1];
      end else begin
         so_ff <= tx_sh_ff[SFM_FRAME_BITS-1];
         tx_sh_ff <= {tx_sh_ff[SFM_FRAME_BITS-2:0], 1'b0};
      end
   end
   // drive only while selected; reset pin forces tri-state
   assign link.so_out = so_ff;
   assign link.so_oe = !link.cs_n && !reset_pin;
   // -----------------------------------------------------------
   // Received bytes into core FIFO
   // -----------------------------------------------------------
   logic wr_s1_ff;  // Byte toggle sync stage 1
   logic wr_s2_ff;  // Byte toggle sync stage 2
   logic wr_s3_ff;  // Previous synced byte toggle
   logic byte_pulse;  // New byte available
   logic fifo_in_ready;  // FIFO can take it
   logic ovf_ff;  // Byte lost on full FIFO
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wr_s1_ff <= 1'b0;
         wr_s2_ff <= 1'b0;
         wr_s3_ff <= 1'b0;
      end else begin
         wr_s1_ff <= wr_tog_ff;
         wr_s2_ff <= wr_s1_ff;
         wr_s3_ff <= wr_s2_ff;
      end
   end
   assign byte_pulse = wr_s2_ff ^ wr_s3_ff;
   // Link cannot stall, so a full FIFO is reported sticky
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ovf_ff <= 1'b0;
      end else if (byte_pulse && !fifo_in_ready) begin
         ovf_ff <= 1'b1;
      end
   end
   assign cfg_overflow = ovf_ff;
   sfm_fifo #(.WIDTH(SFM_FRAME_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .arst_n(arst_n),
      .in_valid(byte_pulse),
      .in_ready(fifo_in_ready),
      .in_data(rx_hold_ff),
      .out_valid(cfg_valid),
      .out_ready(cfg_ready),
      .out_data(cfg_data)
   );
endmodule

// ---- design/sfm_host.sv ----
/*
 File: host SPI master end for the solenoid monitor link.
 Assumes: so_in already resolved by the bench; sclk is derived here from clk.
*/
`timescale 1ns/10ps
module sfm_host
   import sfm_pkg::*;
#(
   parameter int HALF = SFM_SCLK_HALF
) (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Link
   sfm_link_if.host link,
   // Request: one byte frame
   input wire logic req_valid,
   output logic req_ready,
   input wire logic [SFM_FRAME_BITS-1:0] req_data,
   // Answer
   output logic rsp_valid,
   output logic [SFM_FRAME_BITS-1:0] rsp_data
);
   sfm_hstate_e st_ff;  // Host state
   logic [7:0] div_ff;  // Half-period divider
   logic [SFM_CNT_W-1:0] bit_ff;  // Bit index
   logic [SFM_FRAME_BITS-1:0] tx_ff;  // Outgoing shifter
   logic [SFM_FRAME_BITS-1:0] rx_ff;  // Incoming shifter
   logic so_s1_ff;  // so sync stage 1
   logic so_s2_ff;  // so sync stage 2
   logic rsp_ff;  // Answer pulse
   logic half_done;
   assign half_done = (div_ff == 8'(HALF - 1));
   assign req_ready = (st_ff == SFM_H_IDLE);
   assign rsp_valid = rsp_ff;
   assign rsp_data = rx_ff;
   // so synchroniser; sampled late in high phase so sync delay is covered
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         so_s1_ff <= 1'b0;
         so_s2_ff <= 1'b0;
      end else begin
         so_s1_ff <= link.so_in;
         so_s2_ff <= so_s1_ff;
      end
   end
   // Frame sequencer
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_ff <= SFM_H_IDLE;
         div_ff <= SFM_DIV_ZERO;
         bit_ff <= SFM_CNT_ZERO;
         tx_ff <= SFM_BYTE_ZERO;
         rx_ff <= SFM_BYTE_ZERO;
         rsp_ff <= 1'b0;
         link.sclk <= 1'b0;
         link.cs_n <= 1'b1;
         link.si <= 1'b0;
      end else begin
         rsp_ff <= 1'b0;
         div_ff <= half_done ? SFM_DIV_ZERO : div_ff + 1'b1;
         case (st_ff)
            SFM_H_IDLE: begin
               div_ff <= SFM_DIV_ZERO;
               if (req_valid) begin
                  link.cs_n <= 1'b0;
                  tx_ff <= {req_data[SFM_FRAME_BITS-2:0], 1'b0};
                  link.si <= req_data[SFM_FRAME_BITS-1];
                  bit_ff <= SFM_CNT_ZERO;
                  st_ff <= SFM_H_LOW;
               end
            end
            SFM_H_LOW: begin
               if (half_done) begin
                  link.sclk <= 1'b1;
                  st_ff <= SFM_H_HIGH;
               end
            end
            SFM_H_HIGH: begin
               if (half_done) begin
                  // take synced so late in the high phase, as sclk is driven low
                  rx_ff <= {rx_ff[SFM_FRAME_BITS-2:0], so_s2_ff};
                  link.sclk <= 1'b0;
                  link.si <= tx_ff[SFM_FRAME_BITS-1];
                  tx_ff <= {tx_ff[SFM_FRAME_BITS-2:0], 1'b0};
                  bit_ff <= bit_ff + 1'b1;
                  st_ff <= (bit_ff == SFM_LAST_BIT) ? SFM_H_DONE : SFM_H_LOW;
               end
            end
            SFM_H_DONE: begin
               if (half_done) begin
                  link.cs_n <= 1'b1;
                  rsp_ff <= 1'b1;
                  st_ff <= SFM_H_IDLE;
               end
            end
            default: st_ff <= SFM_H_IDLE;
         endcase
      end
   end
endmodule

// ---- verif/sfm_link_monitor.sv ----
/*
 File: concurrent checks on the first SPI link (host end facing device end).
 Assumes: tb instantiates it beside that link; sclk is made from clk by the host.
*/
`timescale 1ns/10ps
module sfm_link_monitor
   import sfm_pkg::*;
#(
   parameter int HALF = SFM_SCLK_HALF
) (
   // Core clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Device reset pin
   input wire logic reset_pin,
   // Link signals
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic si,
   input wire logic so_out,
   input wire logic so_oe
);
   // ------------------------------------------------
   // Helper logic
   // ------------------------------------------------
   logic sclk_q_ff;  // Sclk one cycle ago
   logic [7:0] hi_cnt_ff;  // Length of current high phase
   logic [3:0] bits_ff;  // Rising edges seen in this frame
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   // Edge memory for rise detection
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) sclk_q_ff <= 1'b0;
      else sclk_q_ff <= sclk;
   end
   // High phase counter, cleared while low
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) hi_cnt_ff <= 8'h00;
      else if (sclk) hi_cnt_ff <= hi_cnt_ff + 8'h01;
      else hi_cnt_ff <= 8'h00;
   end
   // Bits per frame, cleared while deselected
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) bits_ff <= 4'h0;
      else if (cs_n) bits_ff <= 4'h0;
      else if (sclk && !sclk_q_ff) bits_ff <= bits_ff + 4'h1;
   end
   // ------------------------------------------------
   // Sequences and assertions
   // ------------------------------------------------
   sequence s_low_phase;
      !sclk [*8];
   endsequence
   sequence s_selected_high;
      !cs_n && $past(!cs_n) && sclk;
   endsequence
   oe_idle_a: assert property (cs_n |-> !so_oe)
      else $error("so driven while deselected");
   oe_drive_a: assert property ($fell(cs_n) && !reset_pin |-> ##[0:2] so_oe)
      else $error("so not driven after select");
   so_fall_a: assert property (s_selected_high |-> $stable(so_out))
      else $error("so changed outside a falling edge");
   rst_tri_a: assert property (reset_pin && $past(reset_pin) |-> !so_oe)
      else $error("so driven during reset pin");
   si_stable_a: assert property (s_selected_high |-> $stable(si))
      else $error("si changed while sclk high");
   idle_clock_a: assert property (cs_n |-> !sclk)
      else $error("sclk active while deselected");
   high_phase_a: assert property ($fell(sclk) |-> hi_cnt_ff == 8'(HALF))
      else $error("sclk high phase length wrong");
   low_phase_a: assert property ($fell(sclk) |-> s_low_phase)
      else $error("sclk low phase too short");
   frame_len_a: assert property ($rose(cs_n) |-> bits_ff == 4'h8)
      else $error("frame not eight bits");
   frame_go_a: assert property ($fell(cs_n) |-> ##[1:20] sclk)
      else $error("no sclk after select");
endmodule

// ---- verif/tb.sv ----
/*
 File: testbench joining host and device ends, plus a second device on a bench link.
 Assumes: design package and link interface compiled first.
*/
`timescale 1ns/10ps
module tb;
   import sfm_pkg::*;
   // ------------------------------------------------
   // Signals
   // ------------------------------------------------
   logic clk, arst_n, reset_pin, reset_pin_2;  // Clocks and pins
   logic req_valid, rsp_valid, req_ready;  // Host handshake
   logic [7:0] req_data, rsp_data, cfg_data, cfg_data_2, si_sh, so_sh;
   logic cfg_valid, cfg_ready, cfg_overflow, cfg_valid_2, cfg_ready_2;
   logic [SFM_CHANNELS-1:0] fault_event, fault_flags;  // Fault path
   logic so_last;  // Last driven so, inverted when released
   int mismatches, checks, k;
   sfm_link_if link();
   sfm_link_if link_2();  // Bench plays a misbehaving host here
   // No pull on so: released line shows the inverse of its last level
   always @(link.so_out or link.so_oe) if (link.so_oe === 1'b1) so_last = link.so_out;
   assign link.so_in = (link.so_oe === 1'b1) ? link.so_out : ~so_last;
   assign link_2.so_in = ~link_2.so_out;
   sfm_host i_sfm_host (.clk(clk), .arst_n(arst_n), .link(link), .req_valid(req_valid),
      .req_ready(req_ready), .req_data(req_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
   sfm_device i_sfm_device (.clk(clk), .arst_n(arst_n), .link(link), .reset_pin(reset_pin),
      .fault_event(fault_event), .fault_flags(fault_flags), .cfg_valid(cfg_valid),
      .cfg_ready(cfg_ready), .cfg_data(cfg_data), .cfg_overflow(cfg_overflow));
   sfm_device i_sfm_device_2 (.clk(clk), .arst_n(arst_n), .link(link_2),
      .reset_pin(reset_pin_2), .fault_event(5'h00), .fault_flags(), .cfg_valid(cfg_valid_2),
      .cfg_ready(cfg_ready_2), .cfg_data(cfg_data_2), .cfg_overflow());
   sfm_link_monitor i_sfm_link_monitor (.clk(clk), .arst_n(arst_n), .reset_pin(reset_pin),
      .sclk(link.sclk), .cs_n(link.cs_n), .si(link.si), .so_out(link.so_out),
      .so_oe(link.so_oe));
   // Wire-level capture on rising sclk, MSB first
   always @(posedge link.sclk) if (link.cs_n === 1'b0) begin
      si_sh <= {si_sh[6:0], link.si};
      so_sh <= {so_sh[6:0], link.so_in};
   end
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // ------------------------------------------------
   // Tasks
   // ------------------------------------------------
   task automatic tick();
      @(posedge clk);
      #1;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // One host frame; checks the answer against the expected faults
   task automatic frame(input logic [7:0] tx, input logic [4:0] ef);
      int n;
      tick();
      req_valid = 1'b1;
      req_data = tx;
      for (n = 0; req_ready !== 1'b1 && n < 600; n++) tick();
      tick();
      req_valid = 1'b0;
      for (n = 0; rsp_valid !== 1'b1 && n < 600; n++) tick();
      // A wait that runs out counts as a mismatch here
      chk({7'h0, rsp_valid}, 8'h01);
      chk({3'h0, rsp_data[6:2]}, {3'h0, ef});
      chk({3'h0, so_sh[6:2]}, {3'h0, ef});
      chk(si_sh, tx);
   endtask
   // Pop one received byte from either device; an edge passes after the pop
   task automatic pop(input bit b, input logic [7:0] e);
      int n;
      for (n = 0; (b ? cfg_valid_2 : cfg_valid) !== 1'b1 && n < 400; n++) tick();
      chk({7'h0, b ? cfg_valid_2 : cfg_valid}, 8'h01);
      chk(b ? cfg_data_2 : cfg_data, e);
      if (b) cfg_ready_2 = 1'b1;
      else cfg_ready = 1'b1;
      tick();
      cfg_ready = 1'b0;
      cfg_ready_2 = 1'b0;
      tick();
   endtask
   // Bench link clock at 160 ns; sel low pulses sclk with select high
   task automatic drv(input logic [7:0] b, input int nb, input bit sel);
      int i;
      #37 link_2.cs_n = !sel;
      for (i = 0; i < nb; i++) begin
         link_2.si = b[7-i];
         #80 link_2.sclk = 1'b1;
         #80 link_2.sclk = 1'b0;
         if (!sel) chk({7'h0, link_2.so_oe}, 8'h00);
      end
      #80 link_2.cs_n = 1'b1;
      link_2.si = ~link_2.si;
      #400;
   endtask
   task automatic end_of_test();
      if (mismatches == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      #300000;
      mismatches++;
      end_of_test();
   end
   // ------------------------------------------------
   // Main sequence
   // ------------------------------------------------
   initial begin
      {arst_n, reset_pin, reset_pin_2, req_valid, cfg_ready, cfg_ready_2} = 6'h00;
      req_data = 8'h00;
      fault_event = 5'h00;
      so_last = 1'b0;
      mismatches = 0;
      checks = 0;
      {link_2.sclk, link_2.cs_n, link_2.si} = 3'h2;
      repeat (4) @(posedge clk);
      #1 arst_n = 1'b1;
      chk({7'h0, link.cs_n}, 8'h01);
      chk({7'h0, link.so_oe}, 8'h00);
      chk({3'h0, fault_flags}, 8'h00);
      // Sticky faults, read and cleared
      fault_event = 5'h15;
      tick();
      fault_event = 5'h00;
      repeat (3) tick();
      chk({3'h0, fault_flags}, 8'h15);
      frame(8'ha5, 5'h15);
      repeat (10) tick();
      chk({3'h0, fault_flags}, 8'h00);
      frame(8'h3c, 5'h00);
      pop(0, 8'ha5);
      pop(0, 8'h3c);
      // Reset pin clears and holds faults clear
      fault_event = 5'h0a;
      tick();
      fault_event = 5'h00;
      repeat (3) tick();
      chk({3'h0, fault_flags}, 8'h0a);
      reset_pin = 1'b1;
      repeat (6) tick();
      chk({3'h0, fault_flags}, 8'h00);
      fault_event = 5'h01;
      tick();
      fault_event = 5'h00;
      repeat (4) tick();
      chk({3'h0, fault_flags}, 8'h00);
      reset_pin = 1'b0;
      repeat (4) tick();
      frame(8'h11, 5'h00);
      pop(0, 8'h11);
      // Fill the byte buffer past full while the reader stalls
      for (k = 0; k < 17; k++) frame(8'(k), 5'h00);
      chk({7'h0, cfg_overflow}, 8'h01);
      for (k = 0; k < 16; k++) pop(0, 8'(k));
      tick();
      chk({7'h0, cfg_valid}, 8'h00);
      // Second device: clock while deselected, then a partial frame
      drv(8'hff, 8, 1'b0);
      drv(8'he0, 3, 1'b1);
      drv(8'h96, 8, 1'b1);
      pop(1, 8'h96);
      repeat (10) tick();
      chk({7'h0, cfg_valid_2}, 8'h00);
      // Reset pin overrides select
      link_2.cs_n = 1'b0;
      #200 chk({7'h0, link_2.so_oe}, 8'h01);
      reset_pin_2 = 1'b1;
      #200 chk({7'h0, link_2.so_oe}, 8'h00);
      reset_pin_2 = 1'b0;
      link_2.cs_n = 1'b1;
      #200 chk({7'h0, link_2.so_oe}, 8'h00);
      end_of_test();
   end
endmodule
